// File: ccu_pkg.sv
// ccu_pkg: shared constants, modes and decode helpers of the ccu block
package ccu_pkg;

  // ---------------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------------
  localparam int unsigned ADDR_W  = 3;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned TIMER_W = 16;
  localparam int unsigned SRC_N   = 8;
  localparam int unsigned DUTY_W  = 10;

  // ---------------------------------------------------------------------
  // register offsets (one byte register per address)
  // ---------------------------------------------------------------------
  localparam logic [2:0] ADDR_UNIT_CONTROL         = 3'h0;
  localparam logic [2:0] ADDR_CAPTURE_INPUT_SELECT = 3'h1;
  localparam logic [2:0] ADDR_VALUE_LOW_BYTE       = 3'h2;
  localparam logic [2:0] ADDR_VALUE_HIGH_REGISTER  = 3'h3;
  localparam logic [2:0] ADDR_EVENT_STATUS         = 3'h4;

  // ---------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------
  localparam int unsigned CTL_EN_BIT   = 7;
  localparam int unsigned CTL_OUT_BIT  = 5;
  localparam int unsigned CTL_FMT_BIT  = 4;
  localparam int unsigned STS_FLAG_BIT = 0;

  // ---------------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------------
  localparam logic [7:0] RST_UNIT_CONTROL         = 8'h00;
  localparam logic [7:0] RST_CAPTURE_INPUT_SELECT = 8'h00;
  localparam logic [7:0] RST_VALUE_LOW_BYTE       = 8'h00;
  localparam logic [7:0] RST_VALUE_HIGH_REGISTER  = 8'h00;

  // ---------------------------------------------------------------------
  // prescaler terminal counts (edges minus one)
  // ---------------------------------------------------------------------
  localparam logic [3:0] PRESCALE_4_LAST  = 4'h3;
  localparam logic [3:0] PRESCALE_16_LAST = 4'hF;

  // ---------------------------------------------------------------------
  // mode codes
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_OFF           = 4'h0,
    MODE_CMP_TOG_CLR   = 4'h1,
    MODE_CMP_TOG       = 4'h2,
    MODE_CAP_BOTH      = 4'h3,
    MODE_CAP_FALL      = 4'h4,
    MODE_CAP_RISE      = 4'h5,
    MODE_CAP_RISE4     = 4'h6,
    MODE_CAP_RISE16    = 4'h7,
    MODE_CMP_SET       = 4'h8,
    MODE_CMP_CLR       = 4'h9,
    MODE_CMP_PULSE     = 4'hA,
    MODE_CMP_PULSE_CLR = 4'hB,
    MODE_PWM_0         = 4'hC,
    MODE_PWM_1         = 4'hD,
    MODE_PWM_2         = 4'hE,
    MODE_PWM_3         = 4'hF
  } ccu_mode_type;

  // decoders used by the unit; is_capture also by the trigger front end
  function automatic logic is_capture(input logic [3:0] m);
    return (m >= MODE_CAP_BOTH) && (m <= MODE_CAP_RISE16);
  endfunction

  function automatic logic is_compare(input logic [3:0] m);
    return (m == MODE_CMP_TOG_CLR) || (m == MODE_CMP_TOG) ||
           ((m >= MODE_CMP_SET) && (m <= MODE_CMP_PULSE_CLR));
  endfunction

  function automatic logic is_pwm(input logic [3:0] m);
    return m[3] & m[2];
  endfunction

endpackage

// File: ccu_trig_if.sv
// ccu_trig_if: mode, trigger select and capture event between unit parts
`timescale 1ns/1ps
interface ccu_trig_if;
  logic [3:0] mode;
  logic [2:0] sel;
  logic       cap_evt;

  modport unit (output mode, output sel, input  cap_evt);
  modport trig (input  mode, input  sel, output cap_evt);
endinterface

// File: ccu_trig.sv
// ccu_trig: capture source sync, select, edge detect and edge prescaler
`timescale 1ns/1ps
module ccu_trig (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  // raw trigger sources, index equals select code
  input  wire logic [7:0] src_i,
  // link to the unit
  ccu_trig_if.trig        bus
);

  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic       prev;
    logic [3:0] cnt;
    logic       evt;
  } ccu_trig_state_type;

  ccu_trig_state_type q_ff;
  ccu_trig_state_type nxt_q;
  logic               lvl;
  logic               rise;
  logic               fall;

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  // sync1 feeds only sync2; the mux looks at the second stage alone
  always_comb begin
    nxt_q       = q_ff;
    nxt_q.sync1 = src_i;
    nxt_q.sync2 = q_ff.sync1;
    lvl         = q_ff.sync2[bus.sel];
    rise        = lvl & ~q_ff.prev;
    fall        = ~lvl & q_ff.prev;
    nxt_q.prev  = lvl;
    nxt_q.evt   = 1'b0;
    if (!ccu_pkg::is_capture(bus.mode)) begin
      nxt_q.cnt = 4'h0;   // off or other modes drop prescaler progress
    end
    if (bus.mode == ccu_pkg::MODE_CAP_BOTH) begin
      nxt_q.evt = rise | fall;
    end
    if (bus.mode == ccu_pkg::MODE_CAP_FALL) begin
      nxt_q.evt = fall;
    end
    if (bus.mode == ccu_pkg::MODE_CAP_RISE) begin
      nxt_q.evt = rise;
      nxt_q.cnt = 4'h0;
    end
    if ((bus.mode == ccu_pkg::MODE_CAP_RISE4 ||
         bus.mode == ccu_pkg::MODE_CAP_RISE16) && rise) begin
      // >= keeps a stale count from a 16 mode from stalling the 4 mode
      if (q_ff.cnt >= ((bus.mode == ccu_pkg::MODE_CAP_RISE4) ?
                       ccu_pkg::PRESCALE_4_LAST :
                       ccu_pkg::PRESCALE_16_LAST)) begin
        nxt_q.evt = 1'b1;
        nxt_q.cnt = 4'h0;
      end else begin
        nxt_q.cnt = q_ff.cnt + 4'h1;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign bus.cap_evt = q_ff.evt;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  // fall mode fires on every fall
  chk_fall_capture: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (bus.mode == ccu_pkg::MODE_CAP_FALL) && fall |=> q_ff.evt)
    else $error("falling edge not captured");
  chk_prescale_range: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (bus.mode == ccu_pkg::MODE_CAP_RISE4) && q_ff.cnt <= 4'h3
      |=> q_ff.cnt <= 4'h3 || bus.mode != ccu_pkg::MODE_CAP_RISE4)
    else $error("divide by four count out of range");

endmodule // ccu_trig

// File: ccu_unit.sv
// ccu_unit: capture/compare/pwm unit with its register port
//
// Overview of operation
// - codes 1100-1111 run pwm on period timer
// - code 0000 turns off, clears state
// - 1010 match gives one low-high-low pulse
// - 1001 match drives output low
// - 1000 match drives output high
// - 0010 match toggles output
// - 0001 match toggles output, clears timer
// - 0100 captures on falling trigger edges
// - 0011 captures on both trigger edges
// - every event sets flag, fires converter trigger
// - three-bit field selects capture source
// - select register bits 7:3 read zero
// - capture loads low value with timer low
// - compare matches low value to timer low
// - right-aligned pwm: low value gives bits 7:0
// - left-aligned pwm: low bits 7:6 only
// - high value supplies upper pwm bits
// - high value captures, matches timer high
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module ccu_unit (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // register port
  input  wire logic [2:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  // timers
  input  wire logic [15:0] sixteen_bit_timer_i,
  input  wire logic [7:0]  period_timer_i,
  input  wire logic [1:0]  period_fine_i,
  input  wire logic        period_reload_i,
  // capture sources
  input  wire logic        remapped_input_pin_i,
  input  wire logic        comparator_one_output_i,
  input  wire logic        comparator_two_output_i,
  input  wire logic        pin_change_event_i,
  input  wire logic [3:0]  logic_cell_output_i,
  // unit outputs
  output logic             unit_out_o,
  output logic             timer_clear_o,
  output logic             adc_trigger_o,
  output logic             unit_event_flag_o
);

  typedef struct packed {
    logic       en;
    logic       fmt;
    logic [3:0] mode;
    logic [2:0] sel;
    logic [7:0] val_lo;
    logic [7:0] val_hi;
    logic       flag;
    logic       out;
    logic       match_prev;
    logic       pulse;
    logic       tmr_clr;
    logic       adc_trig;
    logic [7:0] rdata;
    logic [9:0] duty;
  } ccu_unit_state_type;

  ccu_unit_state_type   q_ff;
  ccu_unit_state_type   nxt_q;
  ccu_pkg::ccu_mode_type eff_mode;
  logic                 match;
  logic                 cmp_evt;
  logic                 cap_evt;
  logic                 pwm_evt;
  logic                 any_evt;
  logic [9:0]           pwm_duty;
  logic [7:0]           src;

  ccu_trig_if trig_bus ();

  assign src = {logic_cell_output_i, pin_change_event_i,
                comparator_two_output_i, comparator_one_output_i,
                remapped_input_pin_i};

  // ---------------------------------------------------------------------
  // capture trigger front end
  // ---------------------------------------------------------------------
  ccu_trig u_trig (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .src_i    (src),
    .bus      (trig_bus.trig)
  );

  // a disabled unit behaves as if the mode were off
  assign eff_mode       = q_ff.en ? ccu_pkg::ccu_mode_type'(q_ff.mode)
                                  : ccu_pkg::MODE_OFF;
  assign trig_bus.mode  = eff_mode;
  assign trig_bus.sel   = q_ff.sel;
  assign cap_evt        = trig_bus.cap_evt & ccu_pkg::is_capture(eff_mode);

  // full 16-bit compare against both value bytes
  assign match   = sixteen_bit_timer_i == {q_ff.val_hi, q_ff.val_lo};
  // only the first cycle of a match counts, a stopped timer fires once
  assign cmp_evt = ccu_pkg::is_compare(eff_mode) & match & ~q_ff.match_prev;
  assign pwm_evt = ccu_pkg::is_pwm(eff_mode) & period_reload_i;
  assign any_evt = cmp_evt | cap_evt | pwm_evt;

  // right format uses high bits 1:0 over the full low byte
  // left format uses low bits 7:6 only
  // left format takes all eight high bits
  assign pwm_duty = q_ff.fmt ? {q_ff.val_hi, q_ff.val_lo[7:6]}
                             : {q_ff.val_hi[1:0], q_ff.val_lo};

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  always_comb begin
    nxt_q          = q_ff;
    nxt_q.tmr_clr  = 1'b0;
    nxt_q.pulse    = 1'b0;
    nxt_q.rdata    = 8'h00;
    nxt_q.match_prev = ccu_pkg::is_compare(eff_mode) & match;

    // software writes first, hardware updates below win
    if (wr_i) begin
      unique case (addr_i)
        ccu_pkg::ADDR_UNIT_CONTROL: begin
          nxt_q.en   = wdata_i[ccu_pkg::CTL_EN_BIT];
          nxt_q.fmt  = wdata_i[ccu_pkg::CTL_FMT_BIT];
          nxt_q.mode = wdata_i[3:0];
        end
        ccu_pkg::ADDR_CAPTURE_INPUT_SELECT: nxt_q.sel = wdata_i[2:0];
        ccu_pkg::ADDR_VALUE_LOW_BYTE:       nxt_q.val_lo = wdata_i;
        ccu_pkg::ADDR_VALUE_HIGH_REGISTER:  nxt_q.val_hi = wdata_i;
        ccu_pkg::ADDR_EVENT_STATUS: begin
          if (wdata_i[ccu_pkg::STS_FLAG_BIT]) begin
            nxt_q.flag = 1'b0;          // write one to clear
          end
        end
        default: ;                      // unmapped offsets ignore writes
      endcase
    end

    // read data appear in the cycle after the strobe only
    if (rd_i) begin
      unique case (addr_i)
        ccu_pkg::ADDR_UNIT_CONTROL: begin
          // output bit shows the live level
          nxt_q.rdata = {q_ff.en, 1'b0, q_ff.out, q_ff.fmt, q_ff.mode};
        end
        ccu_pkg::ADDR_CAPTURE_INPUT_SELECT: nxt_q.rdata = {5'h00, q_ff.sel};
        ccu_pkg::ADDR_VALUE_LOW_BYTE:       nxt_q.rdata = q_ff.val_lo;
        ccu_pkg::ADDR_VALUE_HIGH_REGISTER:  nxt_q.rdata = q_ff.val_hi;
        ccu_pkg::ADDR_EVENT_STATUS:         nxt_q.rdata = {7'h00, q_ff.flag};
        default:                            nxt_q.rdata = 8'h00;
      endcase
    end

    // capture wins over a same-cycle software write
    // high byte captured together with the low byte
    if (cap_evt) begin
      nxt_q.val_lo = sixteen_bit_timer_i[7:0];
      nxt_q.val_hi = sixteen_bit_timer_i[15:8];
    end

    // a running pulse always ends after one cycle high
    if (q_ff.pulse) begin
      nxt_q.out = 1'b0;
    end

    // compare actions
    if (cmp_evt) begin
      if (eff_mode == ccu_pkg::MODE_CMP_TOG ||
          eff_mode == ccu_pkg::MODE_CMP_TOG_CLR) begin
        nxt_q.out     = ~q_ff.out;
        nxt_q.tmr_clr = eff_mode == ccu_pkg::MODE_CMP_TOG_CLR;
      end
      if (eff_mode == ccu_pkg::MODE_CMP_SET) begin
        nxt_q.out = 1'b1;
      end
      if (eff_mode == ccu_pkg::MODE_CMP_CLR) begin
        nxt_q.out = 1'b0;
      end
      if (eff_mode == ccu_pkg::MODE_CMP_PULSE ||
          eff_mode == ccu_pkg::MODE_CMP_PULSE_CLR) begin
        nxt_q.out     = 1'b1;
        nxt_q.pulse   = 1'b1;
        nxt_q.tmr_clr = eff_mode == ccu_pkg::MODE_CMP_PULSE_CLR;
      end
    end

    // pwm on period timer, duty latched at period start
    if (ccu_pkg::is_pwm(eff_mode)) begin
      if (period_reload_i) begin
        nxt_q.duty = pwm_duty;
        nxt_q.out  = pwm_duty != 10'h000;
      end else if ({period_timer_i, period_fine_i} >= q_ff.duty) begin
        nxt_q.out = 1'b0;
      end
    end

    // off clears all internal state except registers
    if (eff_mode == ccu_pkg::MODE_OFF) begin
      nxt_q.out        = 1'b0;
      nxt_q.match_prev = 1'b0;
      nxt_q.pulse      = 1'b0;
      nxt_q.duty       = 10'h000;
    end

    // set wins over a same-cycle clear
    nxt_q.adc_trig = any_evt;
    if (any_evt) begin
      nxt_q.flag = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q_ff        <= '0;
      q_ff.en     <= ccu_pkg::RST_UNIT_CONTROL[ccu_pkg::CTL_EN_BIT];
      q_ff.fmt    <= ccu_pkg::RST_UNIT_CONTROL[ccu_pkg::CTL_FMT_BIT];
      q_ff.mode   <= ccu_pkg::RST_UNIT_CONTROL[3:0];
      q_ff.sel    <= ccu_pkg::RST_CAPTURE_INPUT_SELECT[2:0];
      q_ff.val_lo <= ccu_pkg::RST_VALUE_LOW_BYTE;
      q_ff.val_hi <= ccu_pkg::RST_VALUE_HIGH_REGISTER;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // every output straight from the state register
  assign rdata_o           = q_ff.rdata;
  assign unit_out_o        = q_ff.out;
  assign timer_clear_o     = q_ff.tmr_clr;
  assign adc_trigger_o     = q_ff.adc_trig;
  assign unit_event_flag_o = q_ff.flag;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  chk_off_output: assert property (
    eff_mode == ccu_pkg::MODE_OFF |=> !unit_out_o)
    else $error("output not low while off");
  chk_pulse_shape: assert property (
    cmp_evt && eff_mode == ccu_pkg::MODE_CMP_PULSE
      |=> unit_out_o && !timer_clear_o ##1 !unit_out_o)
    else $error("compare pulse shape wrong");
  chk_pulse_clear: assert property (
    cmp_evt && eff_mode == ccu_pkg::MODE_CMP_PULSE_CLR
      |=> unit_out_o && timer_clear_o ##1 !unit_out_o && !timer_clear_o)
    else $error("pulse with timer clear wrong");
  chk_match_low: assert property (
    cmp_evt && eff_mode == ccu_pkg::MODE_CMP_CLR |=> !unit_out_o)
    else $error("output not cleared on match");
  chk_match_high: assert property (
    cmp_evt && eff_mode == ccu_pkg::MODE_CMP_SET |=> unit_out_o)
    else $error("output not set on match");
  chk_toggle_out: assert property (
    cmp_evt && eff_mode == ccu_pkg::MODE_CMP_TOG
      |=> unit_out_o != $past(unit_out_o) && !timer_clear_o)
    else $error("output not toggled on match");
  chk_toggle_clear: assert property (
    cmp_evt && eff_mode == ccu_pkg::MODE_CMP_TOG_CLR
      |=> unit_out_o != $past(unit_out_o) && timer_clear_o)
    else $error("toggle with timer clear wrong");
  chk_capture_value: assert property (
    cap_evt |=> {q_ff.val_hi, q_ff.val_lo} == $past(sixteen_bit_timer_i))
    else $error("capture did not load timer value");
  chk_event_flag: assert property (
    any_evt |=> unit_event_flag_o && adc_trigger_o)
    else $error("event did not set flag and trigger");
  chk_select_read: assert property (
    rd_i && addr_i == ccu_pkg::ADDR_CAPTURE_INPUT_SELECT
      |=> rdata_o == {5'h00, $past(q_ff.sel)})
    else $error("select register read wrong");
  chk_pwm_start: assert property (
    pwm_evt && pwm_duty != 10'h000 |=> unit_out_o)
    else $error("pwm period did not start high");

  cov_capture: cover property (cap_evt);
  cov_pulse: cover property (cmp_evt &&
    eff_mode == ccu_pkg::MODE_CMP_PULSE_CLR);
  cov_pwm_fall: cover property (ccu_pkg::is_pwm(eff_mode) &&
    unit_out_o ##1 !unit_out_o);

endmodule // ccu_unit

// File: ccu_far_model.sv
// ccu_far_model: timer and period time base on the far side of the unit
`timescale 1ns/1ps
module ccu_far_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // timer control from the bench and the unit
  input  wire logic        run_i,
  input  wire logic        load_i,
  input  wire logic [15:0] load_val_i,
  input  wire logic        timer_clear_i,
  // time bases towards the unit
  output logic      [15:0] sixteen_bit_timer_o,
  output logic      [7:0]  period_timer_o,
  output logic      [1:0]  period_fine_o,
  output logic             period_reload_o
);
  logic [15:0] tmr_ff;
  logic [9:0]  per_ff;

  // -------------------------------------------------------------------
  // 16-bit timer
  // -------------------------------------------------------------------
  // load wins so the bench can park the count at a known value
  // clear on request
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tmr_ff <= 16'h0000;
    end else if (load_i) begin
      tmr_ff <= load_val_i;
    end else if (timer_clear_i) begin
      tmr_ff <= 16'h0000;
    end else if (run_i) begin
      tmr_ff <= tmr_ff + 16'h0001;
    end
  end

  // -------------------------------------------------------------------
  // period time base
  // -------------------------------------------------------------------
  // free running 10-bit count, a period is 1024 cycles
  // period timer as pwm time base
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      per_ff <= 10'h000;
    end else begin
      per_ff <= per_ff + 10'h001;
    end
  end

  assign sixteen_bit_timer_o = tmr_ff;
  assign period_timer_o      = per_ff[9:2];
  assign period_fine_o       = per_ff[1:0];
  assign period_reload_o     = (per_ff == 10'h000);
endmodule // ccu_far_model

// File: tb.sv
// tb: register-level test of the ccu unit against a timer model
`timescale 1ns/1ps
module tb;
  // -------------------------------------------------------------------
  // stimulus and observed signals
  // -------------------------------------------------------------------
  logic        clk_i    = 1'b0;
  logic        resetn_i = 1'b0;
  logic [2:0]  addr     = 3'h0;
  logic [7:0]  wdata    = 8'h00;
  logic        wr       = 1'b0;
  logic        rd       = 1'b0;
  logic [7:0]  src      = 8'h00;
  logic        run      = 1'b0;
  logic        load     = 1'b1;
  logic [15:0] load_val = 16'h0000;
  logic [7:0]  rdata;
  logic [15:0] tmr;
  logic [7:0]  ptmr;
  logic [1:0]  pfine;
  logic        preload;
  logic        out;
  logic        tclr;
  logic        adc;
  logic        flag;
  int          n_fail   = 0;
  int          n_tests  = 0;
  int          n_evt    = 0;

  // 25 MHz
  always #20 clk_i = ~clk_i;

  ccu_unit dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .sixteen_bit_timer_i(tmr),
    .period_timer_i(ptmr), .period_fine_i(pfine),
    .period_reload_i(preload), .remapped_input_pin_i(src[0]),
    .comparator_one_output_i(src[1]), .comparator_two_output_i(src[2]),
    .pin_change_event_i(src[3]), .logic_cell_output_i(src[7:4]),
    .unit_out_o(out), .timer_clear_o(tclr), .adc_trigger_o(adc),
    .unit_event_flag_o(flag));

  ccu_far_model far (
    .clk_i(clk_i), .resetn_i(resetn_i), .run_i(run), .load_i(load),
    .load_val_i(load_val), .timer_clear_i(tclr),
    .sixteen_bit_timer_o(tmr), .period_timer_o(ptmr),
    .period_fine_o(pfine), .period_reload_o(preload));

  // converter trigger pulses, one count per high cycle
  always @(posedge clk_i) if (adc === 1'b1) n_evt = n_evt + 1;

  // -------------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------------
  task automatic results();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_i);
    wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string nm, input logic [2:0] a,
                        input logic [7:0] exp);
    @(posedge clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_i);
    rd   <= 1'b0;
    #1 chk(nm, {8'h00, rdata}, {8'h00, exp});
  endtask

  // bounded wait on the trigger pulse (0) or the period reload (1)
  task automatic wait_for(input bit which, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge clk_i);
      #1;
      if ((which ? preload : adc) === 1'b1) break;
    end
    if (i == lim) begin
      n_fail++;
      $display("CHECK FAILED wait expected 1 seen 0");
      results();
    end
  endtask

  // one compare match at 0x0040; nl is the level left afterwards
  task automatic cmp(input logic [3:0] m, input logic nl,
                     input logic pulse, input logic clr);
    load <= 1'b1;
    wr_reg(0, {4'hE, m});
    load <= 1'b0;
    run  <= 1'b1;
    wait_for(0, 200);
    chk("out at match", {15'h0, out}, {15'h0, nl | pulse});
    chk("timer clear", {15'h0, tclr}, {15'h0, clr});
    chk("flag out", {15'h0, flag}, 16'h0001);
    @(posedge clk_i);
    #1 chk("out after", {15'h0, out}, {15'h0, nl});
    chk("clear after", {15'h0, tclr}, 16'h0000);
    chk("trigger after", {15'h0, adc}, 16'h0000);
    run <= 1'b0;
    rd_chk("control", 0, {2'b10, nl, 1'b0, m});
    rd_chk("flag", 4, 8'h01);
    wr_reg(4, 8'h01);
    rd_chk("flag cleared", 4, 8'h00);
    chk("flag out clear", {15'h0, flag}, 16'h0000);
  endtask

  // 16 trigger pulses on source s, n events expected, with the timer parked at v
  task automatic cap(input logic [3:0] m, input logic [2:0] s,
                     input int n, input logic [15:0] v);
    load_val <= v;
    load     <= 1'b1;
    wr_reg(0, 8'h00);
    wr_reg(4, 8'h01);
    wr_reg(1, {5'h1F, s});
    rd_chk("select", 1, {5'h00, s});
    wr_reg(0, {4'h8, m});
    #1 n_evt = 0;
    repeat (16) begin
      @(posedge clk_i);
      src[s] <= 1'b1;
      repeat (4) @(posedge clk_i);
      src[s] <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    repeat (8) @(posedge clk_i);
    #1 chk("events", 16'(n_evt), 16'(n));
    rd_chk("capture low", 2, v[7:0]);
    rd_chk("capture high", 3, v[15:8]);
    rd_chk("flag", 4, 8'h01);
  endtask

  // high time over one full period equals the duty
  task automatic pwm(input logic fmt, input logic [7:0] hi,
                     input logic [7:0] lo, input int duty,
                     input logic [3:0] m);
    int hi_n;
    hi_n = 0;
    wr_reg(3, hi);
    wr_reg(2, lo);
    wr_reg(0, {3'h4, fmt, m});
    // clear the sticky flag so only a pwm period start can set it again
    wr_reg(4, 8'h01);
    wait_for(1, 1100);
    wait_for(1, 1100);
    repeat (1024) begin
      @(posedge clk_i);
      #1;
      if (out === 1'b1) hi_n++;
    end
    chk("pwm high time", 16'(hi_n), 16'(duty));
    rd_chk("flag", 4, 8'h01);
  endtask

  // -------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    // reset values, unmapped places read zero
    for (int a = 0; a < 8; a++) rd_chk("reset", a[2:0], 8'h00);
    wr_reg(5, 8'hFF);
    rd_chk("unmapped", 5, 8'h00);
    wr_reg(3, 8'h00);
    wr_reg(2, 8'h40);
    cmp(4'h8, 1'b1, 1'b0, 1'b0);
    cmp(4'h9, 1'b0, 1'b0, 1'b0);
    cmp(4'h2, 1'b1, 1'b0, 1'b0);
    cmp(4'h1, 1'b0, 1'b0, 1'b1);
    cmp(4'hA, 1'b0, 1'b1, 1'b0);
    cmp(4'hB, 1'b0, 1'b1, 1'b1);
    cmp(4'h8, 1'b1, 1'b0, 1'b0);
    // mode off drops the output
    wr_reg(0, 8'h80);
    @(posedge clk_i);
    #1 chk("off out", {15'h0, out}, 16'h0000);
    rd_chk("off control", 0, 8'h80);
    cap(4'h3, 3'h0, 32, 16'hC35A);
    cap(4'h4, 3'h1, 16, 16'hA5B4);
    cap(4'h5, 3'h2, 16, 16'h1E2D);
    cap(4'h6, 3'h3, 4, 16'h7788);
    cap(4'h7, 3'h4, 1, 16'h0FF1);
    cap(4'h5, 3'h5, 16, 16'h9A6C);
    cap(4'h4, 3'h6, 16, 16'h3C4B);
    cap(4'h3, 3'h7, 32, 16'hE17F);
    pwm(1'b0, 8'hFE, 8'h05, 517, 4'hC);
    pwm(1'b1, 8'h40, 8'hC5, 259, 4'hF);
    results();
  end
endmodule // tb
